//--- bench/led_mux_and_compliance_test_select_test.sv
`timescale 1ns/1ps
module led_mux_and_compliance_test_select_test;
  import indicator_test_pkg::*;
  logic        clk    = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] addr   = 12'h000;
  logic [15:0] wdata  = 16'h0000;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic        strap  = 1'b1;
  logic        prbs   = 1'b0;
  logic        led0   = 1'b1;
  logic [7:0]  st     = 8'h53;
  logic [15:0] rdata;
  logic        col, pin0, te_en, tx_en, tx_bit;
  logic [3:0]  te_pat;
  logic [5:0]  gap;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles   = 0;
  localparam logic [7:0] VEC_A = 8'h53;
  localparam logic [7:0] VEC_B = 8'hAC;

  always #20 clk = ~clk;

  indicator_test_ctrl #(.BLINK_CYC(4), .STRETCH_CYC(6)) dut_u (
    .I_CORE_CLK(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_STRAP_POLARITY(strap),
    .I_LINK_GOOD(st[0]), .I_RX_ACTIVE(st[1]), .I_TX_ACTIVE(st[2]), .I_COLLISION(st[3]),
    .I_SPEED_100(st[4]), .I_FULL_DUPLEX(st[5]), .I_LPI_STATE(st[6]), .I_MII_ERROR(st[7]),
    .I_PRBS_ERROR(prbs), .I_LED0_DEFAULT(led0), .O_COL_PIN(col),
    .O_INDICATOR_PIN_ZERO(pin0), .O_TE10_TEST_EN(te_en), .O_TE10_PATTERN(te_pat),
    .O_TX100_TEST_EN(tx_en), .O_TX100_BIT(tx_bit));

  line_tester tester_u (.i_clk(clk), .i_en(tx_en), .i_bit(tx_bit), .o_gap(gap));

  task automatic final_report();
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    resetn <= 1'b0;
    strap  <= s;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  // Indicator source as the selected event, before polarity
  function automatic logic src_level(input logic [3:0] c, input logic [7:0] v, input logic lost);
    case (c)
      4'h0: return v[0];
      4'h1, 4'h9: return v[1] | v[2];
      4'h2: return v[2];
      4'h3: return v[1];
      4'h4: return v[3];
      4'h5: return v[4];
      4'h6: return !v[4];
      4'h7: return v[5];
      4'h8: return v[0];
      4'hA: return v[0] & v[4] & v[5];
      4'hB: return v[6];
      4'hC: return v[7];
      4'hD: return lost;
      default: return 1'b0;
    endcase
  endfunction

  // Link blink with activity depends on the blink phase, so that case is not compared
  task automatic show(input logic [3:0] c, input logic [1:0] r, input logic p,
                      input logic [7:0] v, input logic lost);
    logic lvl;
    @(posedge clk);
    st <= v;
    bus_wr(INDICATOR_CONTROL_OFS, {6'h00, p, 2'h0, c, 1'b0, r});
    repeat (3) @(posedge clk);
    @(negedge clk);
    lvl = p ? src_level(c, v, lost) : !src_level(c, v, lost);
    if (!(c == 4'h8 && v[0] && (v[1] | v[2]))) begin
      chk({15'h0, col}, {15'h0, (r == 2'h0) ? lvl : v[3]});
      chk({15'h0, pin0}, {15'h0, (r == 2'h3) ? lvl : led0});
    end
  endtask

  task automatic col_is(input logic exp);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({15'h0, col}, {15'h0, exp});
  endtask

  initial begin
    logic [3:0] pats [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hC};
    do_reset(1'b1);
    bus_rd(INDICATOR_CONTROL_OFS, 16'h0000);
    bus_rd(COMPLIANCE_TEST_CONTROL_OFS, 16'h0000);
    bus_wr(12'h000, 16'h2100);
    bus_wr(INDICATOR_CONTROL_OFS, 16'hFFFF);
    bus_rd(INDICATOR_CONTROL_OFS, 16'hFFFF);
    bus_wr(12'h026, 16'h1234);
    bus_rd(12'h026, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 4; r++) begin
        led0 <= p[0];
        show(4'h0, r[1:0], p[0], VEC_A, 1'b0);
      end
    end
    for (int c = 0; c < 16; c++) show(c[3:0], 2'h0, 1'b1, VEC_A, 1'b0);
    for (int c = 0; c < 16; c++) show(c[3:0], 2'h0, 1'b1, VEC_B, 1'b1);
    bus_rd(BASIC_STATUS_OFS, 16'h0000);
    show(4'hD, 2'h0, 1'b1, VEC_B, 1'b0);
    show(4'hE, 2'h0, 1'b1, VEC_B, 1'b0);
    @(posedge clk);
    prbs <= 1'b1;
    @(posedge clk);
    prbs <= 1'b0;
    col_is(1'b1);
    bus_wr(SELF_TEST_STATUS_ONE_OFS, 16'h0000);
    col_is(1'b1);
    bus_wr(SELF_TEST_STATUS_ONE_OFS, 16'h8000);
    col_is(1'b0);
    show(4'h4, 2'h3, 1'b1, VEC_A, 1'b0);
    show(4'h4, 2'h3, 1'b1, VEC_B, 1'b0);
    show(4'hA, 2'h3, 1'b0, VEC_B, 1'b0);
    show(4'hC, 2'h3, 1'b1, VEC_A, 1'b0);
    show(4'hC, 2'h3, 1'b1, VEC_B, 1'b0);
    foreach (pats[i]) begin
      bus_wr(COMPLIANCE_TEST_CONTROL_OFS, {12'h001, pats[i]});
      @(negedge clk);
      chk({11'h0, te_en, te_pat}, {12'h001, pats[i]});
    end
    bus_wr(COMPLIANCE_TEST_CONTROL_OFS, 16'h0002);
    @(negedge clk);
    chk({15'h0, te_en}, 16'h0000);
    bus_wr(TX100_TEST_CONTROL_OFS, 16'h0010);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({15'h0, tx_en}, 16'h0001);
    chk({10'h0, gap}, 16'h0002);
    // Selection changed without re-enable must not take effect
    bus_wr(COMPLIANCE_TEST_CONTROL_OFS, 16'h0001);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({10'h0, gap}, 16'h0002);
    bus_wr(TX100_TEST_CONTROL_OFS, 16'h0000);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({14'h0, tx_en, tx_bit}, 16'h0000);
    bus_wr(TX100_TEST_CONTROL_OFS, 16'h0030);
    repeat (60) @(posedge clk);
    @(negedge clk);
    chk({10'h0, gap}, 16'h0011);
    bus_rd(TX100_TEST_CONTROL_OFS, 16'h0030);
    bus_wr(TX100_TEST_CONTROL_OFS, 16'h0000);
    bus_wr(TX100_TEST_CONTROL_OFS, 16'h0010);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({10'h0, gap}, 16'h0001);
    bus_wr(TX100_TEST_CONTROL_OFS, 16'h0000);
    bus_wr(COMPLIANCE_TEST_CONTROL_OFS, 16'h0000);
    bus_wr(TX100_TEST_CONTROL_OFS, 16'h0010);
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({14'h0, tx_en, tx_bit}, 16'h0000);
    do_reset(1'b0);
    bus_rd(INDICATOR_CONTROL_OFS, 16'h0200);
    final_report();
  end
endmodule

//--- bench/line_tester.sv
`timescale 1ns/1ps
// Line test receiver: counts the zeros between the last two ones on the 100Base-TX line
module line_tester (
  input  wire logic       i_clk,
  input  wire logic       i_en,
  input  wire logic       i_bit,
  output logic      [5:0] o_gap
);
  logic [5:0] run_q;

  // Run length restarts outside test mode, so the first one after enable records a gap of zero
  always_ff @(posedge i_clk) begin
    if (!i_en) begin
      run_q <= 6'h00;
    end else if (i_bit) begin
      o_gap <= run_q;
      run_q <= 6'h00;
    end else begin
      run_q <= run_q + 6'h01;
    end
  end
  // Gap figures only; repetitive one or zero patterns are not used for harmonic
endmodule

//--- logic/indicator_test_ctrl.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module indicator_test_ctrl
  import indicator_test_pkg::*;
#(
  parameter int unsigned BLINK_CYC   = BLINK_HALF_NS / CLK_PERIOD_NS,
  parameter int unsigned STRETCH_CYC = STRETCH_TIME_NS / CLK_PERIOD_NS
) (
  input  wire logic                               I_CORE_CLK,
  input  wire logic                               I_RESETN,
  input  wire logic [indicator_test_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [indicator_test_pkg::DATA_W-1:0] I_WDATA,
  input  wire logic                               I_WR,
  input  wire logic                               I_RD,
  output logic      [indicator_test_pkg::DATA_W-1:0] O_RDATA,
  input  wire logic                               I_STRAP_POLARITY,
  input  wire logic                               I_LINK_GOOD,
  input  wire logic                               I_RX_ACTIVE,
  input  wire logic                               I_TX_ACTIVE,
  input  wire logic                               I_COLLISION,
  input  wire logic                               I_SPEED_100,
  input  wire logic                               I_FULL_DUPLEX,
  input  wire logic                               I_LPI_STATE,
  input  wire logic                               I_MII_ERROR,
  input  wire logic                               I_PRBS_ERROR,
  input  wire logic                               I_LED0_DEFAULT,
  output logic                                    O_COL_PIN,
  output logic                                    O_INDICATOR_PIN_ZERO,
  output logic                                    O_TE10_TEST_EN,
  output logic      [3:0]                         O_TE10_PATTERN,
  output logic                                    O_TX100_TEST_EN,
  output logic                                    O_TX100_BIT
);
  import indicator_test_pkg::*;

  localparam int BW = $clog2(BLINK_CYC + 1);
  localparam int SW = $clog2(STRETCH_CYC + 1);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [15:0] multi_function_indicator_q, multi_function_indicator_d;
  logic [15:0] compliance_test_control_q, compliance_test_control_d;
  logic [1:0]  tx100_q, tx100_d;
  logic [15:0] rdata_q, rdata_d;
  logic        strap_meta_q;
  logic        strap_sync_q;
  logic [1:0]  strap_cnt_q, strap_cnt_d;
  logic        strap_done_q, strap_done_d;
  logic        link_prev_q;
  logic        lost_q, lost_d;
  logic        prbs_q, prbs_d;
  logic [BW-1:0] blink_cnt_q, blink_cnt_d;
  logic        blink_q, blink_d;
  logic [SW-1:0] stretch_cnt_q, stretch_cnt_d;
  logic        col_q, col_d;
  logic        led0_q, led0_d;
  logic        basic_rd;
  logic        selftest_clr;
  logic        activity;
  logic        stretched;
  logic        ind_active;
  logic        ind_level;
  src_t        src;
  logic [1:0]  route;
  logic        pol;

  assign src          = src_t'(multi_function_indicator_q[SRC_LSB +: 4]);
  assign route        = multi_function_indicator_q[ROUTE_LSB +: 2];
  assign pol          = multi_function_indicator_q[POL_SWAP_BIT];
  assign basic_rd     = I_RD && hit(I_ADDR, BASIC_STATUS_OFS);
  assign selftest_clr = I_WR && hit(I_ADDR, SELF_TEST_STATUS_ONE_OFS)
                        && I_WDATA[ERR_CNT_CLR_BIT];
  assign activity     = I_RX_ACTIVE || I_TX_ACTIVE;
  assign stretched    = (stretch_cnt_q != '0);

  // Indicator source selection
  always_comb begin
    case (src)
      SRC_LINK_OK:    ind_active = I_LINK_GOOD;
      SRC_ACT:        ind_active = activity;
      SRC_TX_ACT:     ind_active = I_TX_ACTIVE;
      SRC_RX_ACT:     ind_active = I_RX_ACTIVE;
      SRC_COLLISION:  ind_active = I_COLLISION;
      SRC_SPEED_100:  ind_active = I_SPEED_100;
      SRC_SPEED_10:   ind_active = !I_SPEED_100;
      SRC_FULL_DUP:   ind_active = I_FULL_DUPLEX;
      SRC_LINK_BLINK: ind_active = I_LINK_GOOD && !(stretched && blink_q);
      SRC_STRETCH:    ind_active = stretched;
      SRC_LINK_100FD: ind_active = I_LINK_GOOD && I_SPEED_100 && I_FULL_DUPLEX;
      SRC_LPI:        ind_active = I_LPI_STATE;
      SRC_MII_ERR:    ind_active = I_MII_ERROR;
      SRC_LINK_LOST:  ind_active = lost_q;
      SRC_PRBS_ERR:   ind_active = prbs_q;
      default:        ind_active = 1'b0;
    endcase
    ind_level = pol ? ind_active : !ind_active;
  end

  always_comb begin
    multi_function_indicator_d        = multi_function_indicator_q;
    compliance_test_control_d       = compliance_test_control_q;
    tx100_d       = tx100_q;
    strap_cnt_d   = strap_cnt_q;
    strap_done_d  = strap_done_q;
    rdata_d       = 16'h0000;
    lost_d        = lost_q;
    prbs_d        = prbs_q;
    blink_cnt_d   = blink_cnt_q;
    blink_d       = blink_q;
    stretch_cnt_d = stretch_cnt_q;

    // Strap sampled only after the synchroniser has settled
    if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_SETTLE_CNT) begin
        multi_function_indicator_d[POL_SWAP_BIT] = !strap_sync_q;
        strap_done_d         = 1'b1;
      end else begin
        strap_cnt_d = strap_cnt_q + 2'h1;
      end
    end

    if (I_WR) begin
      if (hit(I_ADDR, INDICATOR_CONTROL_OFS)) begin
        multi_function_indicator_d = I_WDATA;
      end
      if (hit(I_ADDR, COMPLIANCE_TEST_CONTROL_OFS)) begin
        compliance_test_control_d = I_WDATA;
      end
      if (hit(I_ADDR, TX100_TEST_CONTROL_OFS)) begin
        tx100_d = {I_WDATA[TX100_CODE_BIT], I_WDATA[TX100_EN_BIT]};
      end
    end

    if (I_RD) begin
      if (hit(I_ADDR, INDICATOR_CONTROL_OFS)) begin
        rdata_d = multi_function_indicator_q;
      end else if (hit(I_ADDR, COMPLIANCE_TEST_CONTROL_OFS)) begin
        rdata_d = compliance_test_control_q;
      end else if (hit(I_ADDR, TX100_TEST_CONTROL_OFS)) begin
        rdata_d = 16'h0000;
        rdata_d[TX100_CODE_BIT] = tx100_q[1];
        rdata_d[TX100_EN_BIT]   = tx100_q[0];
      end
    end

    // Set beats clear so a drop during the read is not lost
    if (basic_rd) begin
      lost_d = 1'b0;
    end
    if (link_prev_q && !I_LINK_GOOD) begin
      lost_d = 1'b1;
    end
    if (selftest_clr) begin
      prbs_d = 1'b0;
    end
    if (I_PRBS_ERROR) begin
      prbs_d = 1'b1;
    end

    if (blink_cnt_q == BW'(BLINK_CYC - 1)) begin
      blink_cnt_d = '0;
      blink_d     = !blink_q;
    end else begin
      blink_cnt_d = blink_cnt_q + BW'(1);
    end

    if (activity) begin
      stretch_cnt_d = SW'(STRETCH_CYC);
    end else if (stretched) begin
      stretch_cnt_d = stretch_cnt_q - SW'(1);
    end

    // Unrouted pin keeps its normal function; reserved codes route nowhere
    col_d  = (route == ROUTE_COL)  ? ind_level : I_COLLISION;
    led0_d = (route == ROUTE_LED0) ? ind_level : I_LED0_DEFAULT;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      multi_function_indicator_q        <= INDICATOR_CONTROL_RST;
      compliance_test_control_q       <= COMPLIANCE_TEST_CONTROL_RST;
      tx100_q       <= TX100_TEST_CONTROL_RST;
      rdata_q       <= 16'h0000;
      strap_meta_q  <= 1'b0;
      strap_sync_q  <= 1'b0;
      strap_cnt_q   <= 2'h0;
      strap_done_q  <= 1'b0;
      link_prev_q   <= 1'b0;
      lost_q        <= 1'b0;
      prbs_q        <= 1'b0;
      blink_cnt_q   <= '0;
      blink_q       <= 1'b0;
      stretch_cnt_q <= '0;
      col_q         <= 1'b0;
      led0_q        <= 1'b0;
    end else begin
      multi_function_indicator_q        <= multi_function_indicator_d;
      compliance_test_control_q       <= compliance_test_control_d;
      tx100_q       <= tx100_d;
      rdata_q       <= rdata_d;
      strap_meta_q  <= I_STRAP_POLARITY;
      strap_sync_q  <= strap_meta_q;
      strap_cnt_q   <= strap_cnt_d;
      strap_done_q  <= strap_done_d;
      link_prev_q   <= I_LINK_GOOD;
      lost_q        <= lost_d;
      prbs_q        <= prbs_d;
      blink_cnt_q   <= blink_cnt_d;
      blink_q       <= blink_d;
      stretch_cnt_q <= stretch_cnt_d;
      col_q         <= col_d;
      led0_q        <= led0_d;
    end
  end

  assign O_RDATA              = rdata_q;
  assign O_COL_PIN            = col_q;
  assign O_INDICATOR_PIN_ZERO = led0_q;
  // The waveform generator decodes the select; software keeps the
  // repetitive one and zero codes out of harmonic measurements
  assign O_TE10_TEST_EN       = compliance_test_control_q[TE10_EN_BIT];
  assign O_TE10_PATTERN       = compliance_test_control_q[CFG_LSB +: 4];

  tx100_pattern u_tx100 (
    .i_clk    (I_CORE_CLK),
    .i_resetn (I_RESETN),
    .i_enable (tx100_q[0]),
    .i_code   ({tx100_q[1], compliance_test_control_q[CFG_LSB +: 4]}),
    .o_active (O_TX100_TEST_EN),
    .o_bit    (O_TX100_BIT)
  );

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_link_drop;
    link_prev_q && !I_LINK_GOOD;
  endsequence

  sequence s_no_basic_rd;
    (!basic_rd)[*3];
  endsequence

  a_pol_level: assert property (
    (route == ROUTE_COL && src == SRC_LINK_OK)
    |=> O_COL_PIN == ($past(pol) ? $past(I_LINK_GOOD) : !$past(I_LINK_GOOD)))
    else $error("indicator polarity wrong");

  a_strap_load: assert property (
    $rose(strap_done_q) |-> pol == !$past(strap_sync_q))
    else $error("polarity not loaded from strap");

  a_src_reset: assert property (
    !strap_done_q |-> src == SRC_LINK_OK && route == ROUTE_COL)
    else $error("indicator source not at reset value");

  a_collision_src: assert property (
    (route == ROUTE_LED0 && src == SRC_COLLISION && pol)
    |=> O_INDICATOR_PIN_ZERO == $past(I_COLLISION))
    else $error("collision source wrong");

  a_fd100_src: assert property (
    (route == ROUTE_LED0 && src == SRC_LINK_100FD && !pol)
    |=> O_INDICATOR_PIN_ZERO ==
        !($past(I_LINK_GOOD) && $past(I_SPEED_100) && $past(I_FULL_DUPLEX)))
    else $error("100 full duplex source wrong");

  a_mii_err_src: assert property (
    (route == ROUTE_LED0 && src == SRC_MII_ERR && pol)
    |=> O_INDICATOR_PIN_ZERO == $past(I_MII_ERROR))
    else $error("MII error source wrong");

  a_lost_holds: assert property (
    s_link_drop ##1 s_no_basic_rd |-> lost_q)
    else $error("link lost latch released early");

  a_lost_clear: assert property (
    (basic_rd && !(link_prev_q && !I_LINK_GOOD)) |=> !lost_q)
    else $error("link lost not cleared by read");

  a_prbs_latch: assert property (
    I_PRBS_ERROR ##1 (!selftest_clr)[*2] |=> prbs_q)
    else $error("test error latch released early");

  a_route_other: assert property (
    route == ROUTE_COL |=> O_INDICATOR_PIN_ZERO == $past(I_LED0_DEFAULT))
    else $error("pin zero not on its own function");

  a_te10_enable: assert property (
    (I_WR && hit(I_ADDR, COMPLIANCE_TEST_CONTROL_OFS))
    |=> O_TE10_TEST_EN == $past(I_WDATA[TE10_EN_BIT]))
    else $error("10Base-Te enable not applied");

  a_tx100_gate: assert property (
    !tx100_q[0] |=> !O_TX100_TEST_EN && !O_TX100_BIT)
    else $error("100Base-TX pattern while disabled");

endmodule

//--- logic/indicator_test_pkg.sv
package indicator_test_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [11:0] INDICATOR_CONTROL_OFS       = 12'h025;
  localparam logic [11:0] COMPLIANCE_TEST_CONTROL_OFS = 12'h027;
  localparam logic [11:0] TX100_TEST_CONTROL_OFS      = 12'h428;
  localparam logic [11:0] BASIC_STATUS_OFS            = 12'h001;
  localparam logic [11:0] SELF_TEST_STATUS_ONE_OFS    = 12'h01B;

  // Field positions
  localparam int POL_SWAP_BIT     = 9;
  localparam int SRC_LSB          = 3;
  localparam int ROUTE_LSB        = 0;
  localparam int TE10_EN_BIT      = 4;
  localparam int CFG_LSB          = 0;
  localparam int TX100_EN_BIT     = 4;
  localparam int TX100_CODE_BIT   = 5;
  localparam int ERR_CNT_CLR_BIT  = 15;

  // Reset values and strap settle count
  localparam logic [15:0] INDICATOR_CONTROL_RST       = 16'h0000;
  localparam logic [15:0] COMPLIANCE_TEST_CONTROL_RST = 16'h0000;
  localparam logic [1:0]  TX100_TEST_CONTROL_RST      = 2'h0;
  localparam logic [1:0]  STRAP_SETTLE_CNT            = 2'h2;

  typedef enum logic [3:0] {
    SRC_LINK_OK    = 4'h0,
    SRC_ACT        = 4'h1,
    SRC_TX_ACT     = 4'h2,
    SRC_RX_ACT     = 4'h3,
    SRC_COLLISION  = 4'h4,
    SRC_SPEED_100  = 4'h5,
    SRC_SPEED_10   = 4'h6,
    SRC_FULL_DUP   = 4'h7,
    SRC_LINK_BLINK = 4'h8,
    SRC_STRETCH    = 4'h9,
    SRC_LINK_100FD = 4'hA,
    SRC_LPI        = 4'hB,
    SRC_MII_ERR    = 4'hC,
    SRC_LINK_LOST  = 4'hD,
    SRC_PRBS_ERR   = 4'hE,
    SRC_RESERVED   = 4'hF
  } src_t;

  localparam logic [1:0] ROUTE_COL  = 2'h0;
  localparam logic [1:0] ROUTE_LED0 = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int BLINK_HALF_NS   = 50_000_000;
  localparam int STRETCH_TIME_NS = 50_000_000;

endpackage

//--- logic/tx100_pattern.sv
`timescale 1ns/1ps
module tx100_pattern (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_enable,
  input  wire logic [4:0] i_code,
  output logic            o_active,
  output logic            o_bit
);
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_ONE  = 3'b010,
    ST_ZERO = 3'b100
  } state_t;

  state_t     state_q, state_d;
  logic [4:0] code_q, code_d;
  logic [4:0] cnt_q, cnt_d;
  logic       en_prev_q;
  logic       en_rise;

  assign en_rise = i_enable && !en_prev_q;

  always_comb begin
    state_d = state_q;
    code_d  = code_q;
    cnt_d   = cnt_q;
    // New code is taken only on a fresh enable, so changes need a re-enable
    if (en_rise) begin
      code_d  = i_code;
      cnt_d   = 5'h00;
      state_d = (i_code == 5'h00) ? ST_OFF : ST_ONE;
    end else if (!i_enable) begin
      state_d = ST_OFF;
    end else begin
      case (state_q)
        ST_ONE: begin
          state_d = ST_ZERO;
          cnt_d   = 5'h01;
        end
        ST_ZERO: begin
          if (cnt_q == code_q) begin
            state_d = ST_ONE;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        ST_OFF: state_d = ST_OFF;
        default: state_d = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q   <= ST_OFF;
      code_q    <= 5'h00;
      cnt_q     <= 5'h00;
      en_prev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      code_q    <= code_d;
      cnt_q     <= cnt_d;
      en_prev_q <= i_enable;
    end
  end

  assign o_active = (state_q != ST_OFF);
  assign o_bit    = (state_q == ST_ONE);

  a_code_taken: assert property (@(posedge i_clk) disable iff (!i_resetn)
    en_rise |=> code_q == $past(i_code))
    else $error("pattern code not taken at enable");

  a_one_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_enable && state_q == ST_ONE && code_q == 5'h01) ##1 i_enable |=> o_bit)
    else $error("code one does not give one zero per one");

  a_two_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_enable && state_q == ST_ONE && code_q == 5'h02) ##1 i_enable[*2] |-> !o_bit ##1 o_bit)
    else $error("code two does not give two zeros per one");

  a_zero_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (en_rise && i_code == 5'h00) |=> !o_active && !o_bit)
    else $error("code zero does not clear the pattern");

endmodule
